// ==== core/trm_routing_matrix.sv ====
`timescale 1ns/1ps
`default_nettype none

module trm_routing_matrix #(
    parameter int NUM_MOD = 8,
    parameter int NUM_LVDS = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // differential triggers
    input wire logic [NUM_LVDS-1:0] lvds_in,
    output logic [NUM_LVDS-1:0] lvds_out,
    output logic [NUM_LVDS-1:0] lvds_oe,
    // module first trigger lines
    input wire logic [NUM_MOD-1:0] module_trigger_first_in,
    output logic [NUM_MOD-1:0] module_trigger_first_out,
    output logic [NUM_MOD-1:0] module_trigger_first_oe,
    // module second trigger lines
    input wire logic [NUM_MOD-1:0] module_trigger_second_in,
    output logic [NUM_MOD-1:0] module_trigger_second_out,
    output logic [NUM_MOD-1:0] module_trigger_second_oe,
    // single-ended external trigger
    input wire logic ext_trig_in,
    output logic ext_trig_out,
    output logic input_threshold_select,
    output logic input_impedance_select
);

    localparam int NLINE = NUM_LVDS + 2 * NUM_MOD;

    logic [15:0] line_cfg_reg [NLINE];
    logic [15:0] line_cfg_next [NLINE];
    logic [15:0] ttl_in_reg, ttl_in_next;
    logic [15:0] ttl_out_reg, ttl_out_next;
    logic [15:0] ec01_reg, ec01_next;
    logic [15:0] ec23_reg, ec23_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [3:0] ec_reg, ec_next, ec_prev_reg;
    logic [3:0] ec_rise, ec_fall;
    logic [NLINE-1:0] out_reg, out_next;
    logic ext_out_reg, ext_out_next;
    logic [NLINE:0] pin_all;
    logic [NLINE:0] cond_all;
    logic [15:0] cfg_all [NLINE+1];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] line_addr(input int i);
        logic [7:0] a;
        if (i < NUM_LVDS) begin
            a = trm_pkg::OFS_LVDS_BASE + 8'(2 * i);
        end else if (i < NUM_LVDS + NUM_MOD) begin
            a = trm_pkg::OFS_FIRST_BASE + 8'(2 * (i - NUM_LVDS));
        end else begin
            a = trm_pkg::OFS_SECOND_BASE + 8'(2 * (i - NUM_LVDS - NUM_MOD));
        end
        return a;
    endfunction

    // returns {hit, level}; a reserved code or missing number gives no hit
    function automatic logic [1:0] pick(input logic [2:0] st, input logic [2:0] sn,
                                        input logic [NLINE:0] c);
        logic [1:0] r;
        r = 2'h0;
        case (st)
            trm_pkg::SRC_TTL: r = {1'b1, c[NLINE]};
            trm_pkg::SRC_LVDS: begin
                if (int'(sn) < NUM_LVDS) r = {1'b1, c[int'(sn)]};
            end
            trm_pkg::SRC_FIRST: begin
                if (int'(sn) < NUM_MOD) r = {1'b1, c[NUM_LVDS + int'(sn)]};
            end
            trm_pkg::SRC_SECOND: begin
                if (int'(sn) < NUM_MOD) r = {1'b1, c[NUM_LVDS + NUM_MOD + int'(sn)]};
            end
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NLINE; i++) begin
            line_cfg_next[i] = line_cfg_reg[i];
        end
        ttl_in_next = ttl_in_reg;
        ttl_out_next = ttl_out_reg;
        ec01_next = ec01_reg;
        ec23_next = ec23_reg;
        if (reg_wr) begin
            if (reg_addr == trm_pkg::OFS_TTL_IN) begin
                ttl_in_next = reg_wdata & trm_pkg::MASK_TTL_IN;
            end else if (reg_addr == trm_pkg::OFS_TTL_OUT) begin
                ttl_out_next = reg_wdata & trm_pkg::MASK_TTL_OUT;
            end else if (reg_addr == trm_pkg::OFS_EC01) begin
                ec01_next = reg_wdata & trm_pkg::MASK_EC;
            end else if (reg_addr == trm_pkg::OFS_EC23) begin
                ec23_next = reg_wdata & trm_pkg::MASK_EC;
            end else begin
                for (int i = 0; i < NLINE; i++) begin
                    if (reg_addr == line_addr(i)) begin
                        line_cfg_next[i] = reg_wdata & trm_pkg::MASK_LINE;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // register reads, data valid one cycle later only
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == trm_pkg::OFS_TTL_IN) begin
                rdata_next = ttl_in_reg;
            end else if (reg_addr == trm_pkg::OFS_TTL_OUT) begin
                rdata_next = ttl_out_reg;
            end else if (reg_addr == trm_pkg::OFS_EC01) begin
                rdata_next = ec01_reg;
            end else if (reg_addr == trm_pkg::OFS_EC23) begin
                rdata_next = ec23_reg;
            end else if (reg_addr == trm_pkg::OFS_STAT_EC) begin
                rdata_next = {11'h000, cond_all[NLINE], ec_reg};
            end else if (reg_addr == trm_pkg::OFS_STAT_LVDS) begin
                rdata_next = 16'(cond_all[NUM_LVDS-1:0]);
            end else begin
                for (int i = 0; i < NLINE; i++) begin
                    if (reg_addr == line_addr(i)) rdata_next = line_cfg_reg[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // input conditioning, one cell per input-capable line
    // ------------------------------------------------------------
    assign pin_all = {ext_trig_in, module_trigger_second_in, module_trigger_first_in, lvds_in};

    always_comb begin
        for (int i = 0; i < NLINE; i++) begin
            cfg_all[i] = line_cfg_reg[i];
        end
        cfg_all[NLINE] = ttl_in_reg;
    end

    for (genvar g = 0; g <= NLINE; g++) begin : g_cond
        // an output-configured line never feeds the matrix as an input
        trm_in_cond u_cond (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin_in(pin_all[g]),
            .enable(cfg_all[g][trm_pkg::B_EN] & ~cfg_all[g][trm_pkg::B_DIR]),
            .invert(cfg_all[g][trm_pkg::B_POL]),
            .level_mode(cfg_all[g][trm_pkg::B_EL]),
            .fall_edge(cfg_all[g][trm_pkg::B_RF]),
            .edge_sel(cfg_all[g][trm_pkg::SN_LSB +: 2]),
            .ec_rise(ec_rise),
            .ec_fall(ec_fall),
            .cond_out(cond_all[g])
        );
    end

    // ------------------------------------------------------------
    // edge clocks and output routing
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] eb;
        logic [1:0] s;
        eb = 8'h00;
        s = 2'h0;
        for (int k = 0; k < 4; k++) begin
            eb = (k < 2) ? ec01_reg[8 * k +: 8] : ec23_reg[8 * (k - 2) +: 8];
            s = pick(eb[trm_pkg::ST_LSB +: 3], eb[trm_pkg::SN_LSB +: 3], cond_all);
            ec_next[k] = eb[trm_pkg::EC_EN] & s[1] & s[0];
        end
        for (int i = 0; i < NLINE; i++) begin
            s = pick(line_cfg_reg[i][trm_pkg::ST_LSB +: 3], line_cfg_reg[i][trm_pkg::SN_LSB +: 3],
                     cond_all);
            out_next[i] = (line_cfg_reg[i][trm_pkg::B_EN] & s[1] & s[0])
                          ^ line_cfg_reg[i][trm_pkg::B_POL];
        end
        s = pick(ttl_out_reg[trm_pkg::ST_LSB +: 3], ttl_out_reg[trm_pkg::SN_LSB +: 3], cond_all);
        ext_out_next = (ttl_out_reg[trm_pkg::B_EN] & s[1] & s[0])
                       ^ ttl_out_reg[trm_pkg::B_POL];
    end

    assign ec_rise = ec_reg & ~ec_prev_reg;
    assign ec_fall = ~ec_reg & ec_prev_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NLINE; i++) begin
                line_cfg_reg[i] <= trm_pkg::CFG_RST;
            end
            ttl_in_reg <= trm_pkg::CFG_RST;
            ttl_out_reg <= trm_pkg::CFG_RST;
            ec01_reg <= trm_pkg::CFG_RST;
            ec23_reg <= trm_pkg::CFG_RST;
            rdata_reg <= 16'h0000;
            ec_reg <= 4'h0;
            ec_prev_reg <= 4'h0;
            out_reg <= '0;
            ext_out_reg <= 1'b0;
        end else begin
            for (int i = 0; i < NLINE; i++) begin
                line_cfg_reg[i] <= line_cfg_next[i];
            end
            ttl_in_reg <= ttl_in_next;
            ttl_out_reg <= ttl_out_next;
            ec01_reg <= ec01_next;
            ec23_reg <= ec23_next;
            rdata_reg <= rdata_next;
            ec_reg <= ec_next;
            ec_prev_reg <= ec_reg;
            out_reg <= out_next;
            ext_out_reg <= ext_out_next;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic [NLINE-1:0] pin_oe_all;

    always_comb begin
        for (int i = 0; i < NLINE; i++) begin
            pin_oe_all[i] = line_cfg_reg[i][trm_pkg::B_DIR];
        end
    end

    assign lvds_out = out_reg[NUM_LVDS-1:0];
    assign lvds_oe = pin_oe_all[NUM_LVDS-1:0];
    assign module_trigger_first_out = out_reg[NUM_LVDS +: NUM_MOD];
    assign module_trigger_first_oe = pin_oe_all[NUM_LVDS +: NUM_MOD];
    assign module_trigger_second_out = out_reg[NUM_LVDS + NUM_MOD +: NUM_MOD];
    assign module_trigger_second_oe = pin_oe_all[NUM_LVDS + NUM_MOD +: NUM_MOD];
    assign ext_trig_out = ext_out_reg;
    // 1 selects the +1.4 V threshold, 0 the +2.5 V one
    assign input_threshold_select = ttl_in_reg[trm_pkg::B_LVL];
    // 1 selects the 50 ohm termination, 0 high impedance
    assign input_impedance_select = ttl_in_reg[trm_pkg::B_IMP];
    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ext_out_off_a: assert property (
        !ttl_out_reg[trm_pkg::B_EN] |=> ext_trig_out == $past(ttl_out_reg[trm_pkg::B_POL]))
        else $error("disabled output not at inactive level");

    ext_out_rsv_a: assert property (
        ttl_out_reg[trm_pkg::ST_LSB + 2] |=> ext_trig_out == $past(ttl_out_reg[trm_pkg::B_POL]))
        else $error("reserved source code drove output");

    ext_out_route_a: assert property (
        ttl_out_reg[trm_pkg::B_EN] && ttl_out_reg[trm_pkg::ST_LSB +: 3] == 3'h0
        |=> ext_trig_out == $past(cond_all[NLINE] ^ ttl_out_reg[trm_pkg::B_POL]))
        else $error("single-ended output does not follow its source");

    dir_write_a: assert property (
        reg_wr && reg_addr == trm_pkg::OFS_LVDS_BASE
        |=> lvds_oe[0] == $past(reg_wdata[trm_pkg::B_DIR]))
        else $error("direction write not seen on line enable");

    thresh_sel_a: assert property (
        reg_wr && reg_addr == trm_pkg::OFS_TTL_IN
        |=> input_threshold_select == $past(reg_wdata[trm_pkg::B_LVL]))
        else $error("threshold select not updated");

    imped_sel_a: assert property (
        reg_wr && reg_addr == trm_pkg::OFS_TTL_IN
        |=> input_impedance_select == $past(reg_wdata[trm_pkg::B_IMP]))
        else $error("impedance select not updated");

    rdata_pulse_a: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read answer cycle");

    ec_source_a: assert property (
        !ec01_reg[trm_pkg::EC_EN] ##1 !ec01_reg[trm_pkg::EC_EN] |-> !ec_reg[0] && !ec_rise[0])
        else $error("disabled edge clock active");

endmodule // trm_routing_matrix

`default_nettype wire

// ==== core/trm_pkg.sv ====
package trm_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses, 16-bit registers)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_LVDS_BASE = 8'h00;
    localparam logic [7:0] OFS_FIRST_BASE = 8'h10;
    localparam logic [7:0] OFS_SECOND_BASE = 8'h20;
    localparam logic [7:0] OFS_TTL_IN = 8'h50;
    localparam logic [7:0] OFS_TTL_OUT = 8'h52;
    localparam logic [7:0] OFS_EC01 = 8'h58;
    localparam logic [7:0] OFS_EC23 = 8'h5a;
    localparam logic [7:0] OFS_STAT_EC = 8'h5c;
    localparam logic [7:0] OFS_STAT_LVDS = 8'h5e;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_EN = 15;
    localparam int B_LVL = 14;
    localparam int B_IMP = 13;
    localparam int B_POL = 11;
    localparam int B_RF = 10;
    localparam int B_EL = 9;
    localparam int B_DIR = 8;
    localparam int ST_LSB = 4;
    localparam int SN_LSB = 0;
    localparam int EC_EN = 7;

    // ------------------------------------------------------------
    // writable bits and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_LINE = 16'h8f77;
    localparam logic [15:0] MASK_TTL_IN = 16'hee03;
    localparam logic [15:0] MASK_TTL_OUT = 16'h8877;
    localparam logic [15:0] MASK_EC = 16'hf7f7;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [2:0] SYNC_RST = 3'h0;

    // ------------------------------------------------------------
    // source type codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_TTL = 3'h0,
        SRC_LVDS = 3'h1,
        SRC_FIRST = 3'h2,
        SRC_SECOND = 3'h3
    } trm_src_t;

endpackage

// ==== core/trm_in_cond.sv ====
`timescale 1ns/1ps
`default_nettype none

module trm_in_cond (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // trigger pin
    input wire logic pin_in,
    // configuration
    input wire logic enable,
    input wire logic invert,
    input wire logic level_mode,
    input wire logic fall_edge,
    input wire logic [1:0] edge_sel,
    // edge clock events
    input wire logic [3:0] ec_rise,
    input wire logic [3:0] ec_fall,
    // conditioned trigger
    output logic cond_out
);

    logic [2:0] sync_reg, sync_next;
    logic stable_reg, stable_next;
    logic latch_reg, latch_next;
    logic out_reg, out_next;
    logic inv_level, edge_hit;

    // ------------------------------------------------------------
    // sync, invert, pass or latch
    // ------------------------------------------------------------
    always_comb begin
        sync_next = {sync_reg[1:0], pin_in};
        // only a level seen on two late stages counts, filters runt glitches
        stable_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : stable_reg;
        inv_level = stable_reg ^ invert;
        edge_hit = fall_edge ? ec_fall[edge_sel] : ec_rise[edge_sel];
        latch_next = edge_hit ? inv_level : latch_reg;
        out_next = enable & (level_mode ? inv_level : latch_next);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_reg <= trm_pkg::SYNC_RST;
            stable_reg <= 1'b0;
            latch_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
            stable_reg <= stable_next;
            latch_reg <= latch_next;
            out_reg <= out_next;
        end
    end

    assign cond_out = out_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence edge_capt_s;
        enable && !level_mode && edge_hit;
    endsequence

    sequence edge_idle_s;
        enable && !level_mode && !edge_hit;
    endsequence

    level_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        enable && level_mode |=> cond_out == $past(inv_level))
        else $error("level mode output does not follow input");

    edge_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
        edge_capt_s |=> cond_out == $past(inv_level))
        else $error("edge mode output not captured on selected edge");

    edge_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        edge_idle_s ##1 edge_idle_s |=> $stable(cond_out))
        else $error("edge mode output moved without edge");

    in_disabled_a: assert property (@(posedge clk) disable iff (sys_rst)
        !enable |=> !cond_out)
        else $error("disabled input trigger not low");

endmodule // trm_in_cond

`default_nettype wire

// ==== verification/trm_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// far side: modules and connectors drive lines the carrier does not
// ------------------------------------------------------------
module trm_far_side (
    // carrier side
    input wire logic [7:0] lvds_out,
    input wire logic [7:0] lvds_oe,
    input wire logic [7:0] first_out,
    input wire logic [7:0] first_oe,
    input wire logic [7:0] second_out,
    input wire logic [7:0] second_oe,
    // far-side drive levels
    input wire logic [7:0] drv_lvds,
    input wire logic [7:0] drv_first,
    input wire logic [7:0] drv_second,
    input wire logic drv_ext,
    // resolved wire levels
    output logic [7:0] lvds_in,
    output logic [7:0] first_in,
    output logic [7:0] second_in,
    output logic ext_in
);
    // a line the carrier drives carries its level; otherwise the far side drives it
    assign lvds_in = (lvds_oe & lvds_out) | (~lvds_oe & drv_lvds);
    assign first_in = (first_oe & first_out) | (~first_oe & drv_first);
    assign second_in = (second_oe & second_out) | (~second_oe & drv_second);
    // dedicated input connector, never driven by the carrier
    assign ext_in = drv_ext;
endmodule // trm_far_side

`default_nettype wire

// ==== verification/trm_routing_matrix_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module trm_routing_matrix_tb;
    typedef struct packed {
        logic [7:0] src_a;
        logic [15:0] src_c;
        logic [7:0] dst_a;
        logic [15:0] dst_c;
        logic in_v;
        logic exp_v;
    } trm_row_t;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ext_trig_in, ext_trig_out;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_v;
    logic [7:0] lvds_in, lvds_out, lvds_oe, f_in, f_out, f_oe, s_in, s_out, s_oe;
    logic [7:0] d_lv = 8'h00, d_f = 8'h00, d_s = 8'h00;
    logic d_e = 1'b0, thr, imp;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    trm_row_t rows [14];

    always #4 clk = ~clk;

    trm_routing_matrix u_trm_routing_matrix (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .lvds_in(lvds_in), .lvds_out(lvds_out), .lvds_oe(lvds_oe),
        .module_trigger_first_in(f_in), .module_trigger_first_out(f_out),
        .module_trigger_first_oe(f_oe), .module_trigger_second_in(s_in),
        .module_trigger_second_out(s_out), .module_trigger_second_oe(s_oe),
        .ext_trig_in(ext_trig_in), .ext_trig_out(ext_trig_out),
        .input_threshold_select(thr), .input_impedance_select(imp));

    trm_far_side u_trm_far_side (.lvds_out(lvds_out), .lvds_oe(lvds_oe), .first_out(f_out),
        .first_oe(f_oe), .second_out(s_out), .second_oe(s_oe), .drv_lvds(d_lv),
        .drv_first(d_f), .drv_second(d_s), .drv_ext(d_e), .lvds_in(lvds_in),
        .first_in(f_in), .second_in(s_in), .ext_in(ext_trig_in));

    // ------------------------------------------------------------
    // bus, drive and compare helpers
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_read(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // line address selects which far-side level changes
    task automatic drive_line(input logic [7:0] a, input logic v);
        @(posedge clk);
        if (a == 8'h50) d_e <= v;
        else if (a < 8'h10) d_lv[a[3:1]] <= v;
        else if (a < 8'h20) d_f[a[3:1]] <= v;
        else d_s[a[3:1]] <= v;
    endtask

    function automatic logic pick(input logic [7:0] a, input logic [7:0] lv, input logic [7:0] f,
                                  input logic [7:0] s, input logic e);
        if (a == 8'h52) return e;
        if (a < 8'h10) return lv[a[3:1]];
        if (a < 8'h20) return f[a[3:1]];
        return s[a[3:1]];
    endfunction

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic rf;
        rows[0] = '{8'h00, 16'h8200, 8'h02, 16'h8110, 1'b1, 1'b1};
        rows[1] = '{8'h00, 16'h8200, 8'h02, 16'h8110, 1'b0, 1'b0};
        rows[2] = '{8'h00, 16'h8a00, 8'h02, 16'h8110, 1'b1, 1'b0};
        rows[3] = '{8'h00, 16'h8200, 8'h02, 16'h8910, 1'b1, 1'b0};
        rows[4] = '{8'h00, 16'h8200, 8'h14, 16'h8110, 1'b1, 1'b1};
        rows[5] = '{8'h00, 16'h8200, 8'h26, 16'h8110, 1'b1, 1'b1};
        rows[6] = '{8'h00, 16'h8200, 8'h52, 16'h8010, 1'b1, 1'b1};
        rows[7] = '{8'h12, 16'h8200, 8'h04, 16'h8121, 1'b1, 1'b1};
        rows[8] = '{8'h28, 16'h8200, 8'h06, 16'h8134, 1'b1, 1'b1};
        rows[9] = '{8'h50, 16'h8200, 8'h08, 16'h8100, 1'b1, 1'b1};
        rows[10] = '{8'h00, 16'h8200, 8'h0a, 16'h8940, 1'b1, 1'b1};
        rows[11] = '{8'h00, 16'h8200, 8'h0a, 16'h0110, 1'b1, 1'b0};
        rows[12] = '{8'h00, 16'h8200, 8'h52, 16'h8840, 1'b1, 1'b1};
        rows[13] = '{8'h50, 16'h8200, 8'h52, 16'h8000, 1'b1, 1'b1};
        wait_clk(12);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            reg_write(rows[i].src_a, rows[i].src_c);
            reg_write(rows[i].dst_a, rows[i].dst_c);
            @(posedge clk);
            {d_lv, d_f, d_s, d_e} <= '0;
            drive_line(rows[i].src_a, rows[i].in_v);
            wait_clk(12);
            check("row out", 16'(pick(rows[i].dst_a, lvds_out, f_out, s_out, ext_trig_out)),
                  16'(rows[i].exp_v));
            if (rows[i].dst_a != 8'h52) begin
                check("row oe", 16'(pick(rows[i].dst_a, lvds_oe, f_oe, s_oe, 1'b0)),
                      16'h0001);
            end
        end
        $display("test routing rows done");
        // reset state and register access
        sys_rst <= 1'b1;
        wait_clk(12);
        sys_rst <= 1'b0;
        check("oe after reset", {lvds_oe, f_oe}, 16'h0000);
        check("out after reset", {lvds_out, f_out}, 16'h0000);
        reg_write(8'h00, 16'hffff);
        reg_read(8'h00);
        check("line readback", rd_v, trm_pkg::MASK_LINE);
        reg_write(8'h58, 16'hffff);
        reg_read(8'h58);
        check("edge clock readback", rd_v, trm_pkg::MASK_EC);
        reg_write(8'h40, 16'hffff);
        reg_read(8'h40);
        check("unmapped read", rd_v, 16'h0000);
        reg_write(8'h50, 16'h6000);
        #1 check("threshold and impedance", {14'h0, thr, imp}, 16'h0003);
        reg_write(8'h50, 16'h0000);
        #1 check("threshold and impedance", {14'h0, thr, imp}, 16'h0000);
        $display("test registers done");
        // one input to every other differential line
        reg_write(8'h00, 16'h8200);
        for (int i = 1; i < 8; i++) reg_write(8'(2 * i), 16'h8110);
        drive_line(8'h00, 1'b1);
        wait_clk(12);
        check("fan out", {9'h0, lvds_out[7:1]}, 16'h007f);
        // only lvds0 is an enabled input, output lines feed nothing back
        reg_read(8'h5e);
        check("lvds status", rd_v, 16'h0001);
        $display("test fan out done");
        // edge mode on each edge clock, both edges, lvds1 as the clock
        reg_write(8'h02, 16'h8200);
        reg_write(8'h04, 16'h8110);
        for (int k = 0; k < 4; k++) begin
            rf = k[0];
            drive_line(8'h02, rf);
            reg_write(8'h58 + 8'(2 * (k / 2)), 16'h0091 << (8 * (k % 2)));
            reg_write(8'h00, 16'h8000 | 16'(k) | (16'(rf) << 10));
            drive_line(8'h00, 1'b1);
            wait_clk(12);
            drive_line(8'h02, ~rf);
            wait_clk(12);
            check("latched high", 16'(lvds_out[2]), 16'h0001);
            drive_line(8'h00, 1'b0);
            wait_clk(12);
            check("held without edge", 16'(lvds_out[2]), 16'h0001);
            drive_line(8'h02, rf);
            wait_clk(12);
            check("other edge ignored", 16'(lvds_out[2]), 16'h0001);
            drive_line(8'h02, ~rf);
            wait_clk(12);
            check("latched low", 16'(lvds_out[2]), 16'h0000);
        end
        $display("test edge mode done");
        print_verdict();
    end
endmodule // trm_routing_matrix_tb

`default_nettype wire
